/* File: hw/ses_status_unit.sv */
// Summary of operation
// - Clear-status zeroes the event register, pulses clear_others
// - Clear-status idles both operation-complete trackers
// - Enable command loads 0..255 into enable mask
// - Event bits: OPC0 QYE2 DDE3 EXE4 CME5 URQ6 PON7
// - Masked event sets no summary bit
// - Any enabled event sets summary bit
// - Command and query errors always latch
// - Bit 1 and bits 8..15 stay zero
// - Enable query returns mask unchanged
// - Event query returns register then clears
// - OPC sets bit after pending work ends
// - OPC query queues ASCII one when idle
// - Service enable write and read back
// - Status byte query includes summary bit
// - Wait holds later commands until idle
// - Reset command restores default setup
// - Save/recall setup at parameter location
// - Self-test runs ROM checksum, returns result
// - Identification query returns identity response
// - Trigger pulses trig_pulse for one cycle
// - Event register cleared at power-up
// - Reading empty output queue raises query error
`timescale 1ns/1ps
`default_nettype none
module ses_status_unit #(
  parameter int ROM_WORDS = 16,
  parameter logic [7:0] ROM_SUM = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Command from parser
  input wire logic cmd_valid,
  input wire ses_pkg::ses_cmd_e cmd_code,
  input wire logic [15:0] cmd_param,
  output logic cmd_ready,
  // Device activity and events
  input wire logic op_busy,
  input wire logic ev_dde,
  input wire logic ev_exe,
  input wire logic ev_urq,
  input wire logic read_empty,
  // Response to output queue
  output logic rsp_valid,
  output ses_pkg::ses_rsp_e rsp_kind,
  output logic [15:0] rsp_data,
  // Device side effects
  output logic trig_pulse,
  output logic [15:0] setup,
  output logic clear_others,
  // Status
  output logic [15:0] event_reg,
  output logic [15:0] enable_mask,
  output logic [7:0] status_byte
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RCL, ST_TST} ses_state_e;

  typedef struct packed {
    ses_state_e state;
    logic [15:0] esr;
    logic [15:0] ese;
    logic [7:0] sre;
    logic esb;
    logic opc_pend;
    logic opcq_pend;
    logic pon_seen;
    logic rsp_valid;
    ses_pkg::ses_rsp_e rsp_kind;
    logic [15:0] rsp_data;
    logic trig;
    logic [15:0] setup;
    logic clr;
    logic [7:0] stb;
  } ses_s;
  ses_s st;
  ses_s next_st;

  logic tst_start;
  logic tst_busy;
  logic tst_done;
  logic tst_pass;
  ses_mem_if #(.AW(3), .DW(ses_pkg::SES_SETUP_WIDTH)) mif ();

  ses_setup_mem #(.DEPTH(ses_pkg::SES_SETUP_SLOTS), .AW(3), .DW(ses_pkg::SES_SETUP_WIDTH)) u_mem (
    .clk(clk),
    .m(mif.mem)
  );

  ses_rom_check #(.WORDS(ROM_WORDS), .EXPECT(ROM_SUM)) u_rom (
    .clk(clk),
    .srst(srst),
    .start(tst_start),
    .busy(tst_busy),
    .done(tst_done),
    .pass(tst_pass)
  );

  function automatic logic summary(input logic [15:0] ev, input logic [15:0] en);
    summary = |(ev & en & ses_pkg::SES_USED_MASK);
  endfunction : summary

  function automatic logic [7:0] stb_of(input logic [7:0] sre, input logic esb);
    stb_of = 8'h00;
    stb_of[ses_pkg::SES_BIT_ESB] = esb;
    stb_of[6] = |(sre & stb_of);
  endfunction : stb_of

  logic accept;
  logic idle_now;
  logic [15:0] ev_set;
  assign idle_now = !op_busy && !tst_busy;
  // Commands arriving while work is pending wait here
  // A queued one-reply holds commands off until the device is idle and the reply goes out, so two replies never collide
  assign accept = cmd_valid && (st.state == ST_IDLE) && idle_now && !st.opcq_pend;
  assign tst_start = accept && (cmd_code == ses_pkg::SES_CMD_TST_Q);

  always_comb begin
    mif.wr = accept && (cmd_code == ses_pkg::SES_CMD_SAV);
    mif.addr = 3'(cmd_param);
    mif.wdata = st.setup;
  end

  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.trig = 1'b0;
    next_st.clr = 1'b0;
    ev_set = 16'h0000;
    ev_set[ses_pkg::SES_BIT_DDE] = ev_dde;
    ev_set[ses_pkg::SES_BIT_EXE] = ev_exe;
    ev_set[ses_pkg::SES_BIT_URQ] = ev_urq;
    ev_set[ses_pkg::SES_BIT_QYE] = read_empty;
    ev_set[ses_pkg::SES_BIT_PON] = !st.pon_seen;
    next_st.pon_seen = 1'b1;
    if (st.opc_pend && idle_now && !cmd_valid) begin
      ev_set[ses_pkg::SES_BIT_OPC] = 1'b1;
      next_st.opc_pend = 1'b0;
    end
    if (st.opcq_pend && idle_now) begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp_kind = ses_pkg::SES_RSP_ONE;
      next_st.rsp_data = {8'h00, ses_pkg::SES_ASCII_ONE};
      next_st.opcq_pend = 1'b0;
    end
    unique case (st.state)
      ST_IDLE: begin
        if (accept) begin
          unique case (cmd_code)
            ses_pkg::SES_CMD_CLS: begin
              next_st.esr = 16'h0000;
              next_st.clr = 1'b1;
              next_st.opc_pend = 1'b0;
              next_st.opcq_pend = 1'b0;
            end
            ses_pkg::SES_CMD_ESE: next_st.ese = {8'h00, cmd_param[7:0]};
            ses_pkg::SES_CMD_ESE_Q: begin
              next_st.rsp_valid = 1'b1;
              next_st.rsp_kind = ses_pkg::SES_RSP_NUM;
              next_st.rsp_data = st.ese;
            end
            ses_pkg::SES_CMD_ESR_Q: begin
              next_st.rsp_valid = 1'b1;
              next_st.rsp_kind = ses_pkg::SES_RSP_NUM;
              next_st.rsp_data = st.esr;
              next_st.esr = 16'h0000;
            end
            ses_pkg::SES_CMD_IDN_Q: begin
              next_st.rsp_valid = 1'b1;
              next_st.rsp_kind = ses_pkg::SES_RSP_IDN;
              next_st.rsp_data = 16'h0000;
            end
            ses_pkg::SES_CMD_OPC: next_st.opc_pend = 1'b1;
            ses_pkg::SES_CMD_OPC_Q: next_st.opcq_pend = 1'b1;
            ses_pkg::SES_CMD_RCL: begin
              if (int'(cmd_param) < ses_pkg::SES_SETUP_SLOTS) next_st.state = ST_RCL;
              else ev_set[ses_pkg::SES_BIT_EXE] = 1'b1;
            end
            ses_pkg::SES_CMD_RST: next_st.setup = ses_pkg::SES_SETUP_DEFAULT;
            ses_pkg::SES_CMD_SAV: begin
              if (int'(cmd_param) >= ses_pkg::SES_SETUP_SLOTS) ev_set[ses_pkg::SES_BIT_EXE] = 1'b1;
            end
            ses_pkg::SES_CMD_SRE: next_st.sre = cmd_param[7:0];
            ses_pkg::SES_CMD_SRE_Q: begin
              next_st.rsp_valid = 1'b1;
              next_st.rsp_kind = ses_pkg::SES_RSP_NUM;
              next_st.rsp_data = {8'h00, st.sre};
            end
            ses_pkg::SES_CMD_STB_Q: begin
              next_st.rsp_valid = 1'b1;
              next_st.rsp_kind = ses_pkg::SES_RSP_NUM;
              next_st.rsp_data = {8'h00, stb_of(st.sre, st.esb)};
            end
            ses_pkg::SES_CMD_TRG: next_st.trig = 1'b1;
            ses_pkg::SES_CMD_TST_Q: next_st.state = ST_TST;
            ses_pkg::SES_CMD_WAI: next_st.state = ST_WAIT;
            default: ev_set[ses_pkg::SES_BIT_CME] = 1'b1;
          endcase
        end
      end
      ST_RCL: begin
        next_st.setup = mif.rdata;
        next_st.state = ST_IDLE;
      end
      ST_TST: begin
        if (tst_done) begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_kind = ses_pkg::SES_RSP_TST;
          next_st.rsp_data = {15'h0000, !tst_pass};
          next_st.state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Later commands stay refused until the device is idle again
        if (idle_now) next_st.state = ST_IDLE;
      end
    endcase
    // New events win over the clear in the same cycle
    next_st.esr = (next_st.esr | ev_set) & ses_pkg::SES_USED_MASK;
    next_st.esb = summary(next_st.esr, next_st.ese);
    next_st.stb = stb_of(next_st.sre, next_st.esb);
    // The only reset is the power-on one, so power-on is reported after each release
    if (srst) begin
      next_st = '0;
      next_st.state = ST_IDLE;
      next_st.esr = ses_pkg::SES_EVENT_RESET;
      next_st.ese = ses_pkg::SES_ENABLE_RESET;
      next_st.sre = ses_pkg::SES_SRE_RESET;
      next_st.setup = ses_pkg::SES_SETUP_DEFAULT;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Ready stays combinational so a device turning busy refuses in that same cycle
  assign cmd_ready = (st.state == ST_IDLE) && idle_now && !st.opcq_pend;
  assign rsp_valid = st.rsp_valid;
  assign rsp_kind = st.rsp_kind;
  assign rsp_data = st.rsp_data;
  assign trig_pulse = st.trig;
  assign setup = st.setup;
  assign clear_others = st.clr;
  assign event_reg = st.esr;
  assign enable_mask = st.ese;
  assign status_byte = st.stb;

  chk_unused_bits_zero: assert property (
    @(posedge clk) disable iff (srst) (st.esr & ~ses_pkg::SES_USED_MASK) == 16'h0000)
    else $error("unused event bit set");
  chk_summary_matches: assert property (
    @(posedge clk) disable iff (srst) status_byte[ses_pkg::SES_BIT_ESB] == (|(event_reg & enable_mask)))
    else $error("summary mismatch");
  chk_ese_load: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_ESE |=> st.ese == {8'h00, $past(cmd_param[7:0])})
    else $error("enable mask not loaded");
  chk_esr_read_clear: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_ESR_Q && ev_set == 16'h0000
    |=> rsp_valid && rsp_data == $past(st.esr) && st.esr == 16'h0000)
    else $error("event query wrong");
  chk_cmd_error: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_BAD |=> st.esr[ses_pkg::SES_BIT_CME])
    else $error("command error lost");
  chk_query_error: assert property (
    @(posedge clk) disable iff (srst) read_empty |=> st.esr[ses_pkg::SES_BIT_QYE])
    else $error("query error lost");
  chk_cls_idle: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_CLS |=> !st.opc_pend && !st.opcq_pend)
    else $error("trackers not idled");
  chk_wait_hold: assert property (
    @(posedge clk) disable iff (srst) op_busy |-> !cmd_ready)
    else $error("command taken while busy");
  chk_ese_query: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_ESE_Q |=> rsp_data == $past(st.ese) && st.ese == $past(st.ese))
    else $error("enable query wrong");
  chk_sre_load: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_SRE |=> st.sre == $past(cmd_param[7:0]))
    else $error("service enable not loaded");
  chk_cls_pulse: assert property (
    @(posedge clk) disable iff (srst) accept && cmd_code == ses_pkg::SES_CMD_CLS |=> clear_others)
    else $error("clear of other registers missing");
  chk_opc_waits: assert property (
    @(posedge clk) disable iff (srst) st.opc_pend && !idle_now |=> st.opc_pend)
    else $error("operation complete left waiting early");
  chk_opc_sets: assert property (
    @(posedge clk) disable iff (srst)
    st.opc_pend && idle_now && !cmd_valid |=> st.esr[ses_pkg::SES_BIT_OPC])
    else $error("operation complete bit not set");
  chk_one_reply: assert property (
    @(posedge clk) disable iff (srst)
    st.opcq_pend && idle_now |=> rsp_valid && rsp_kind == ses_pkg::SES_RSP_ONE
    && rsp_data == {8'h00, ses_pkg::SES_ASCII_ONE})
    else $error("one reply missing");
  chk_wai_refuses: assert property (
    @(posedge clk) disable iff (srst) st.state == ST_WAIT |-> !cmd_ready)
    else $error("command taken while waiting");
  chk_trig_pulse: assert property (
    @(posedge clk) disable iff (srst) accept && cmd_code == ses_pkg::SES_CMD_TRG |=> trig_pulse)
    else $error("trigger pulse missing");
  chk_test_reply: assert property (
    @(posedge clk) disable iff (srst)
    st.state == ST_TST && tst_done |=> rsp_valid && rsp_kind == ses_pkg::SES_RSP_TST)
    else $error("self-test reply missing");
  chk_slot_range: assert property (
    @(posedge clk) disable iff (srst)
    accept && (cmd_code == ses_pkg::SES_CMD_SAV || cmd_code == ses_pkg::SES_CMD_RCL)
    && int'(cmd_param) >= ses_pkg::SES_SETUP_SLOTS |=> st.esr[ses_pkg::SES_BIT_EXE])
    else $error("bad slot not flagged");
  chk_rst_default: assert property (
    @(posedge clk) disable iff (srst)
    accept && cmd_code == ses_pkg::SES_CMD_RST |=> setup == ses_pkg::SES_SETUP_DEFAULT)
    else $error("setup not restored");
endmodule : ses_status_unit
`default_nettype wire

/* File: common/ses_pkg.sv */
`default_nettype none
package ses_pkg;
  // Common command codes presented by the command parser
  typedef enum logic [4:0] {
    SES_CMD_CLS, SES_CMD_ESE, SES_CMD_ESE_Q, SES_CMD_ESR_Q, SES_CMD_IDN_Q,
    SES_CMD_OPC, SES_CMD_OPC_Q, SES_CMD_RCL, SES_CMD_RST, SES_CMD_SAV,
    SES_CMD_SRE, SES_CMD_SRE_Q, SES_CMD_STB_Q, SES_CMD_TRG, SES_CMD_TST_Q,
    SES_CMD_WAI, SES_CMD_BAD
  } ses_cmd_e;

  // Response kinds placed on the response port
  typedef enum logic [2:0] {
    SES_RSP_NUM, SES_RSP_ONE, SES_RSP_IDN, SES_RSP_TST
  } ses_rsp_e;

  // Standard event bit positions
  localparam int SES_BIT_OPC = 0;
  localparam int SES_BIT_QYE = 2;
  localparam int SES_BIT_DDE = 3;
  localparam int SES_BIT_EXE = 4;
  localparam int SES_BIT_CME = 5;
  localparam int SES_BIT_URQ = 6;
  localparam int SES_BIT_PON = 7;
  // Event summary position in the status byte
  localparam int SES_BIT_ESB = 5;
  // Used bits: B0 and B2..B7; B1 and B8..B15 carry nothing
  localparam logic [15:0] SES_USED_MASK = 16'h00FD;
  localparam logic [15:0] SES_EVENT_RESET = 16'h0000;
  localparam logic [15:0] SES_ENABLE_RESET = 16'h0000;
  localparam logic [7:0] SES_SRE_RESET = 8'h00;
  localparam logic [7:0] SES_ASCII_ONE = 8'h31;
  localparam int SES_SETUP_SLOTS = 5;
  localparam int SES_SETUP_WIDTH = 16;
  localparam logic [15:0] SES_SETUP_DEFAULT = 16'h0000;
endpackage : ses_pkg
`default_nettype wire

/* File: common/ses_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ses_mem_if #(parameter int AW = 3, parameter int DW = 16);
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output wr, output addr, output wdata, input rdata);
  modport mem (input wr, input addr, input wdata, output rdata);
endinterface : ses_mem_if
`default_nettype wire

/* File: hw/ses_setup_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ses_setup_mem #(
  parameter int DEPTH = 5,
  parameter int AW = 3,
  parameter int DW = 16
) (
  // Clock
  input wire logic clk,
  // Port
  ses_mem_if.mem m
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] cells;
    logic [DW-1:0] rdata;
  } ses_mem_s;
  ses_mem_s st;
  ses_mem_s next_st;

  initial begin
    if (DEPTH > (1 << AW)) $error("ses_setup_mem: DEPTH exceeds address range");
  end

  // No reset: stored setups survive a device reset by design
  always_comb begin
    next_st = st;
    if (m.wr && (int'(m.addr) < DEPTH)) begin
      next_st.cells[m.addr] = m.wdata;
    end
    next_st.rdata = (int'(m.addr) < DEPTH) ? st.cells[m.addr] : '0;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign m.rdata = st.rdata;
endmodule : ses_setup_mem
`default_nettype wire

/* File: hw/ses_rom_check.sv */
`timescale 1ns/1ps
`default_nettype none
module ses_rom_check #(
  parameter int WORDS = 16,
  parameter logic [7:0] EXPECT = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done,
  output logic pass
);
  localparam int CW = $clog2(WORDS + 1);
  typedef struct packed {
    logic run;
    logic [CW-1:0] idx;
    logic [7:0] sum;
    logic done;
    logic pass;
  } ses_rom_s;
  ses_rom_s st;
  ses_rom_s next_st;

  initial begin
    if (WORDS < 1) $error("ses_rom_check: WORDS must be positive");
  end

  // Program memory contents stand in as a fixed table
  function automatic logic [7:0] rom_word(input logic [CW-1:0] i);
    rom_word = 8'(i) ^ 8'hA5;
  endfunction : rom_word

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (st.run) begin
      next_st.sum = st.sum + rom_word(st.idx);
      next_st.idx = st.idx + CW'(1);
      if (int'(st.idx) == WORDS - 1) begin
        next_st.run = 1'b0;
        next_st.done = 1'b1;
        next_st.pass = ((st.sum + rom_word(st.idx)) == EXPECT);
      end
    end else if (start) begin
      next_st.run = 1'b1;
      next_st.idx = '0;
      next_st.sum = 8'h00;
    end
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign busy = st.run;
  assign done = st.done;
  assign pass = st.pass;
endmodule : ses_rom_check
`default_nettype wire

/* File: verif/ses_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ses_host_model (
  // Clock
  input wire logic clk,
  // Command handshake
  output logic cmd_valid,
  output ses_pkg::ses_cmd_e cmd_code,
  output logic [15:0] cmd_param,
  input wire logic cmd_ready,
  // Hang flag
  output logic hang
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = ses_pkg::SES_CMD_CLS;
    cmd_param = 16'h0000;
    hang = 1'b0;
  end

  // A slow host waits some edges before presenting
  task automatic send(input ses_pkg::ses_cmd_e c, input logic [15:0] p, input int lag);
    int n;
    repeat (lag) @(posedge clk);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_param = p;
    n = 0;
    while (n < 60) begin
      @(negedge clk);
      if (cmd_ready === 1'b1) break;
      n++;
    end
    if (n == 60) hang = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // Released lines show garbage so stale values cannot pass
    cmd_code = ses_pkg::ses_cmd_e'(~c);
    cmd_param = ~p;
  endtask : send
endmodule : ses_host_model
`default_nettype wire

/* File: verif/std_event_status_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module std_event_status_unit_tb;
  logic clk, srst, op_busy, ev_dde, ev_exe, ev_urq, read_empty;
  logic cmd_valid, cmd_ready, rsp_valid, trig_pulse, clear_others, hang;
  ses_pkg::ses_cmd_e cmd_code;
  ses_pkg::ses_rsp_e rsp_kind;
  logic [15:0] cmd_param, rsp_data, setup, event_reg, enable_mask, got, e;
  logic [7:0] status_byte, m;
  logic [2:0] kind;
  int err_total, cmp_count, trig_n, clr_n, rnd;
  logic [7:0] wt [9] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hFF};
  int pos [5] = '{3, 4, 6, 2, 5};

  // Checksum of the four stand-in program words, so a good self-test answers zero
  localparam logic [7:0] ROM_GOOD = 8'h96;

  ses_status_unit #(.ROM_WORDS(4), .ROM_SUM(ROM_GOOD)) i_ses_status_unit (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param),
    .cmd_ready(cmd_ready), .op_busy(op_busy), .ev_dde(ev_dde), .ev_exe(ev_exe), .ev_urq(ev_urq),
    .read_empty(read_empty), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_data(rsp_data),
    .trig_pulse(trig_pulse), .setup(setup), .clear_others(clear_others), .event_reg(event_reg),
    .enable_mask(enable_mask), .status_byte(status_byte));

  ses_host_model i_ses_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_param(cmd_param), .cmd_ready(cmd_ready), .hang(hang));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (trig_pulse === 1'b1) trig_n++;
    if (clear_others === 1'b1) clr_n++;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  always @(posedge hang) begin
    err_total++;
    give_verdict();
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic esb(input logic [15:0] ev, input logic [7:0] mk);
    return |(ev & {8'h00, mk} & ses_pkg::SES_USED_MASK);
  endfunction : esb

  task automatic cmd(input ses_pkg::ses_cmd_e c, input logic [15:0] p);
    i_ses_host_model.send(c, p, $urandom % 3);
  endtask : cmd

  // Capture the one-cycle response while it stands
  task automatic grab;
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      err_total++;
      give_verdict();
    end else begin
      got = rsp_data;
      kind = rsp_kind;
    end
  endtask : grab

  task automatic q(input ses_pkg::ses_cmd_e c);
    cmd(c, 16'h0000);
    grab();
  endtask : q

  task automatic fire(input int b);
    @(posedge clk);
    #1;
    {ev_dde, ev_exe, ev_urq, read_empty} = 4'b1000 >> b;
    @(posedge clk);
    #1;
    {ev_dde, ev_exe, ev_urq, read_empty} = 4'b0000;
  endtask : fire

  initial begin
    rnd = $urandom(55);
    {srst, op_busy, ev_dde, ev_exe, ev_urq, read_empty} = 6'b100000;
    err_total = 0;
    cmp_count = 0;
    trig_n = 0;
    clr_n = 0;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    chk(event_reg, 16'h0000);
    q(ses_pkg::SES_CMD_ESR_Q);
    chk(got, 16'h0080);
    chk(event_reg, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      m = (i < 9) ? wt[i] : 8'($urandom);
      cmd(ses_pkg::SES_CMD_ESE, {8'h00, m});
      q(ses_pkg::SES_CMD_ESE_Q);
      chk(got, {8'h00, m});
      chk(enable_mask, {8'h00, m});
    end
    for (int b = 0; b < 5; b++) begin
      m = 8'($urandom);
      e = 16'h0001 << pos[b];
      cmd(ses_pkg::SES_CMD_ESE, {8'h00, m});
      cmd(ses_pkg::SES_CMD_CLS, 16'h0000);
      chk(event_reg, 16'h0000);
      if (b == 4) cmd(ses_pkg::SES_CMD_BAD, 16'h0000);
      else fire(b);
      repeat (3) @(negedge clk);
      chk(event_reg, e);
      chk(status_byte[5], esb(e, m));
    end
    chk(clr_n, 5);
    cmd(ses_pkg::SES_CMD_CLS, 16'h0000);
    repeat (2) @(negedge clk);
    chk(status_byte[5], 1'b0);
    m = 8'($urandom);
    cmd(ses_pkg::SES_CMD_SRE, {8'h00, m});
    q(ses_pkg::SES_CMD_SRE_Q);
    chk(got, {8'h00, m});
    cmd(ses_pkg::SES_CMD_ESE, 16'h0008);
    fire(0);
    repeat (2) @(negedge clk);
    q(ses_pkg::SES_CMD_STB_Q);
    chk(got, {8'h00, 1'b0, m[5], 1'b1, 5'h00});
    cmd(ses_pkg::SES_CMD_CLS, 16'h0000);
    // Busy rises just after the take, so the work is still pending behind the command
    cmd(ses_pkg::SES_CMD_OPC, 16'h0000);
    op_busy = 1'b1;
    repeat (6) @(negedge clk);
    chk(cmd_ready, 1'b0);
    chk(event_reg[0], 1'b0);
    @(posedge clk);
    #1 op_busy = 1'b0;
    repeat (3) @(negedge clk);
    chk(event_reg[0], 1'b1);
    cmd(ses_pkg::SES_CMD_OPC_Q, 16'h0000);
    op_busy = 1'b1;
    repeat (4) @(negedge clk);
    chk(rsp_valid, 1'b0);
    @(posedge clk);
    #1 op_busy = 1'b0;
    grab();
    chk(got, {8'h00, ses_pkg::SES_ASCII_ONE});
    chk(kind, ses_pkg::SES_RSP_ONE);
    cmd(ses_pkg::SES_CMD_CLS, 16'h0000);
    cmd(ses_pkg::SES_CMD_SAV, 16'd5);
    repeat (3) @(negedge clk);
    chk(event_reg[4], 1'b1);
    cmd(ses_pkg::SES_CMD_RST, 16'h0000);
    cmd(ses_pkg::SES_CMD_SAV, 16'd2);
    cmd(ses_pkg::SES_CMD_RCL, 16'd2);
    repeat (4) @(negedge clk);
    chk(setup, ses_pkg::SES_SETUP_DEFAULT);
    rnd = trig_n;
    cmd(ses_pkg::SES_CMD_TRG, 16'h0000);
    repeat (3) @(negedge clk);
    chk(trig_n, rnd + 1);
    q(ses_pkg::SES_CMD_IDN_Q);
    chk(kind, ses_pkg::SES_RSP_IDN);
    q(ses_pkg::SES_CMD_TST_Q);
    chk(kind, ses_pkg::SES_RSP_TST);
    chk(got, 16'h0000);
    cmd(ses_pkg::SES_CMD_WAI, 16'h0000);
    chk(cmd_ready, 1'b0);
    q(ses_pkg::SES_CMD_ESE_Q);
    chk(got, 16'h0008);
    give_verdict();
  end
endmodule : std_event_status_unit_tb
`default_nettype wire
